// >>> cmt_min_track.sv
// Purpose: One channel's minimum code store, split into high and low bytes
// Assumes: Reads and samples arrive as one-cycle strobes on sys_clk
// Notes:   A read reloads its byte; a sample in the same cycle still counts
module cmt_min_track
    import cmt_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic sample_valid, // New code for this channel
    input wire logic [11:0] sample_code, // Conversion code
    input wire logic rd_lo, // Low byte is being read
    input wire logic rd_hi, // High byte is being read
    output logic [7:0] min_lo, // Low byte of held minimum
    output logic [7:0] min_hi // High byte of held minimum
);

    logic [7:0] lo_r;
    logic [7:0] lo_nxt;
    logic [7:0] hi_r;
    logic [7:0] hi_nxt;
    logic [7:0] base_lo;
    logic [7:0] base_hi;
    logic [15:0] cand;

    always_comb begin
        // Reload after a read, then let a sample compete with that
        base_lo = rd_lo ? CMT_MIN_RESET : lo_r;
        base_hi = rd_hi ? CMT_MIN_RESET : hi_r;
        cand = {sample_code, CMT_LOW_PAD};
        lo_nxt = base_lo;
        hi_nxt = base_hi;
        if (sample_valid && (cand < {base_hi, base_lo})) begin
            hi_nxt = cand[15:8];
            lo_nxt = cand[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lo_r <= CMT_MIN_RESET;
            hi_r <= CMT_MIN_RESET;
        end else begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
        end
    end

    assign min_lo = lo_r;
    assign min_hi = hi_r;

endmodule : cmt_min_track

// >>> cmt_pkg.sv
// Purpose: Shared constants for the channel minimum tracker register bank
// Assumes: 8-bit register data, 8-bit register offsets, 12-bit codes
// Notes:   Codes are stored MSB aligned across the high and low bytes
package cmt_pkg;

    localparam int CMT_DATA_W = 8;
    localparam int CMT_ADDR_W = 8;
    localparam int CMT_CODE_W = 12;
    localparam int CMT_CHAN_W = 3;
    localparam int CMT_NUM_TRACK = 4;

    // First tracked channel number
    localparam logic [2:0] CMT_FIRST_CHAN = 3'h4;

    // Register offsets
    localparam logic [7:0] MIN_CODE_CH4_LOW = 8'h88;
    localparam logic [7:0] MIN_CODE_CH4_HIGH = 8'h89;
    localparam logic [7:0] MIN_CODE_CH5_LOW = 8'h8a;
    localparam logic [7:0] MIN_CODE_CH5_HIGH = 8'h8b;
    localparam logic [7:0] MIN_CODE_CH6_LOW = 8'h8c;
    localparam logic [7:0] MIN_CODE_CH6_HIGH = 8'h8d;
    localparam logic [7:0] MIN_CODE_CH7_LOW = 8'h8e;
    localparam logic [7:0] MIN_CODE_CH7_HIGH = 8'h8f;

    // Offset window base; bits [2:1] pick the channel, bit 0 the byte
    localparam logic [4:0] CMT_BANK_BASE = 5'h11;
    localparam int CMT_BYTE_SEL_BIT = 0;
    localparam int CMT_CHAN_SEL_LSB = 1;

    // Reset and reload values
    localparam logic [7:0] CMT_MIN_RESET = 8'hff;
    localparam logic [7:0] CMT_UNMAPPED_DATA = 8'h00;
    localparam logic [3:0] CMT_LOW_PAD = 4'h0;

endpackage : cmt_pkg

// >>> cmt_regs.sv
// Purpose: Read-only bank of minimum code registers for channels 4 to 7
// Assumes: Register port and conversion results share sys_clk
// Notes:   Read data is registered and answered one cycle after the strobe
module cmt_regs
    import cmt_pkg::*;
(
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic reg_rd, // Register read strobe
    input wire logic reg_wr, // Register write strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data, unused by this bank
    output logic [7:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid pulse
    output logic reg_hit, // Offset lies in this bank (combinational)
    input wire logic conv_valid, // Conversion result strobe
    input wire logic [2:0] conv_chan, // Channel of the result
    input wire logic [11:0] conv_code // Conversion code
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic in_bank;
    logic [1:0] sel_chan;
    logic sel_high;
    logic rd_go;

    always_comb begin
        in_bank = (reg_addr[7:3] == CMT_BANK_BASE);
        sel_chan = reg_addr[CMT_CHAN_SEL_LSB +: 2];
        sel_high = reg_addr[CMT_BYTE_SEL_BIT];
        // Only the read strobe can reload a tracker
        rd_go = reg_rd && in_bank;
    end

    assign reg_hit = in_bank;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel trackers

    logic [7:0] min_lo [CMT_NUM_TRACK];
    logic [7:0] min_hi [CMT_NUM_TRACK];
    logic [CMT_NUM_TRACK-1:0] trk_valid;
    logic [CMT_NUM_TRACK-1:0] trk_rd_lo;
    logic [CMT_NUM_TRACK-1:0] trk_rd_hi;

    for (genvar g = 0; g < CMT_NUM_TRACK; g++) begin : g_trk
        always_comb begin
            trk_valid[g] = conv_valid
                && (conv_chan == (CMT_FIRST_CHAN + 3'(g)));
            trk_rd_lo[g] = rd_go && !sel_high
                && (sel_chan == 2'(g));
            trk_rd_hi[g] = rd_go && sel_high
                && (sel_chan == 2'(g));
        end

        cmt_min_track cmt_min_track_inst (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .sample_valid(trk_valid[g]),
            .sample_code(conv_code),
            .rd_lo(trk_rd_lo[g]),
            .rd_hi(trk_rd_hi[g]),
            .min_lo(min_lo[g]),
            .min_hi(min_hi[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Named register fields, one per byte register

    logic [7:0] lowest_code_c4_lo;
    logic [7:0] lowest_code_c4_hi;
    logic [7:0] lowest_code_c5_lo;
    logic [7:0] lowest_code_c5_hi;
    logic [7:0] lowest_code_c6_lo;
    logic [7:0] lowest_code_c6_hi;
    logic [7:0] lowest_code_c7_lo;
    logic [7:0] lowest_code_c7_hi;

    assign lowest_code_c4_lo = min_lo[0];
    assign lowest_code_c4_hi = min_hi[0];
    assign lowest_code_c5_lo = min_lo[1];
    assign lowest_code_c5_hi = min_hi[1];
    assign lowest_code_c6_lo = min_lo[2];
    assign lowest_code_c6_hi = min_hi[2];
    assign lowest_code_c7_lo = min_lo[3];
    assign lowest_code_c7_hi = min_hi[3];

    ////////////////////////////////////////////////////////////////////////
    // Read return; writes have no path into the trackers

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    always_comb begin
        rvalid_nxt = reg_rd;
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            // The byte as held before this edge's reload is returned
            case (reg_addr)
                MIN_CODE_CH4_LOW: rdata_nxt = lowest_code_c4_lo;
                MIN_CODE_CH4_HIGH: rdata_nxt = lowest_code_c4_hi;
                MIN_CODE_CH5_LOW: rdata_nxt = lowest_code_c5_lo;
                MIN_CODE_CH5_HIGH: rdata_nxt = lowest_code_c5_hi;
                MIN_CODE_CH6_LOW: rdata_nxt = lowest_code_c6_lo;
                MIN_CODE_CH6_HIGH: rdata_nxt = lowest_code_c6_hi;
                MIN_CODE_CH7_LOW: rdata_nxt = lowest_code_c7_lo;
                MIN_CODE_CH7_HIGH: rdata_nxt = lowest_code_c7_hi;
                default: rdata_nxt = CMT_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_r <= CMT_UNMAPPED_DATA;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Write strobe and data reach nothing: the bank is read-only
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

endmodule : cmt_regs

// >>> cmt_regs_properties.sv
// Purpose: Assertions on the minimum tracker register port
// Assumes: One clock, reset_n synchronous and active low
// Notes:   Bound to every cmt_regs instance
module cmt_regs_properties
    import cmt_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic reg_rd, // Read strobe
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_addr, // Offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic reg_rvalid, // Read valid
    input wire logic reg_hit, // Bank hit
    input wire logic conv_valid, // Result strobe
    input wire logic [2:0] conv_chan, // Result channel
    input wire logic [11:0] conv_code // Result code
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    rvalid_timing_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after strobe");
    hit_decode_a: assert property (reg_hit ==
        (reg_addr >= MIN_CODE_CH4_LOW && reg_addr <= MIN_CODE_CH7_HIGH))
        else $error("bank hit decode wrong");
    unmapped_zero_a: assert property (reg_rd && !reg_hit |=>
        reg_rdata == CMT_UNMAPPED_DATA) else $error("unmapped read not zero");
    reread_reload_a: assert property (
        (reg_rd && reg_hit && !conv_valid)
        ##1 (reg_rd && $stable(reg_addr) && !conv_valid) |=>
        reg_rdata == CMT_MIN_RESET)
        else $error("second read did not see reload");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=>
        !reg_rvalid && reg_rdata == CMT_UNMAPPED_DATA)
        else $error("outputs not reset");
endmodule : cmt_regs_properties
////////////////////////////////////////////////////////////////////////
bind cmt_regs cmt_regs_properties cmt_regs_properties_inst (.*);

// >>> cmt_regs_tb.sv
// Purpose: Self-checking bench for the minimum tracker register bank
// Assumes: Reads answered one cycle after the strobe
// Notes:   Byte model reloads on read, then takes a same-cycle sample
module cmt_regs_tb import cmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset_n = 0, reg_rd = 0, reg_wr = 0, conv_valid = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic reg_rvalid, reg_hit;
    logic [2:0] conv_chan = 0;
    logic [11:0] conv_code = 0;
    logic [7:0] mdl [8];
    logic [7:0] q [$];
    logic qh [$];
    logic hit_seen;
    logic [31:0] r;
    int fails = 0, n_compared = 0, seed = 32'hcbf2;
    always #10 sys_clk = ~sys_clk;
    cmt_regs cmt_regs_inst (.*);
    task automatic finish_test;
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] x, input logic [7:0] y);
        n_compared++;
        if (x !== y) begin
            fails++;
            $display("[FAIL] reg_rdata exp %h got %h", x, y);
        end
    endtask : chk
    task automatic chk_hit(input logic x, input logic y);
        n_compared++;
        if (x !== y) begin
            fails++;
            $display("[FAIL] reg_hit exp %h got %h", x, y);
        end
    endtask : chk_hit
    ////////////////////////////////////////////////////////////////////
    task automatic step(input logic rd, wr, cv, input logic [7:0] a,
                        input logic [2:0] ch, input logic [11:0] c);
        logic [2:0] k;
        logic hit;
        k = {ch[1:0], 1'h0};
        hit = (a >= MIN_CODE_CH4_LOW) && (a <= MIN_CODE_CH7_HIGH);
        @(posedge sys_clk);
        reg_rd <= rd;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= c[7:0];
        conv_valid <= cv;
        conv_chan <= ch;
        conv_code <= c;
        if (rd) begin
            q.push_back(hit ? mdl[a[2:0]] : CMT_UNMAPPED_DATA);
            qh.push_back(hit);
            if (hit) begin
                mdl[a[2:0]] = CMT_MIN_RESET;
            end
        end
        if (cv && ch[2] && {c, 4'h0} < {mdl[k + 3'h1], mdl[k]}) begin
            mdl[k + 3'h1] = c[11:4];
            mdl[k] = {c[3:0], 4'h0};
        end
    endtask : step
    always @(posedge sys_clk) begin
        if (reg_rvalid === 1'h1) begin
            chk(q.pop_front(), reg_rdata);
            chk_hit(qh.pop_front(), hit_seen);
        end
        hit_seen = reg_hit;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        mdl = '{default: 8'hff};
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            step('1, '0, '0, {5'h11, i[2:0]}, '0, '0);
        end
        step('0, '0, '1, '0, 3'h5, 12'h123);
        step('1, '0, '0, MIN_CODE_CH5_HIGH, '0, '0);
        step('1, '0, '0, MIN_CODE_CH5_HIGH, '0, '0);
        step('1, '0, '0, MIN_CODE_CH5_LOW, '0, '0);
        step('0, '1, '0, MIN_CODE_CH5_HIGH, '0, '0);
        step('1, '0, '0, MIN_CODE_CH5_HIGH, '0, '0);
        repeat (2000) begin
            r = $random(seed);
            step(r[0], r[1], r[2] | r[3], {r[4] ? 5'h11 : r[12:8], r[7:5]},
                 r[15:13], r[27:16]);
        end
        step('0, '0, '1, '0, 3'h6, 12'h001);
        step('0, '0, '0, '0, '0, '0);
        reset_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        mdl = '{default: CMT_MIN_RESET};
        step('1, '0, '0, MIN_CODE_CH6_LOW, '0, '0);
        step('1, '0, '0, MIN_CODE_CH6_HIGH, '0, '0);
        repeat (3) step('0, '0, '0, '0, '0, '0);
        if (q.size() != 0) begin
            fails++;
            $display("[FAIL] reg_rvalid missing exp 0 got %0d", q.size());
        end
        finish_test;
    end
endmodule : cmt_regs_tb
